/* File: hdl/dcec_top.sv */
`timescale 1ns/1ps
module dcec_top
    import dcec_pkg::*;
#(
    parameter int NCH = DCEC_NUM_CH,
    parameter int CW  = DCEC_COUNT_W
)
(
    input  logic                    clk,
    input  logic                    rstn,
    input  logic                    ce,
    input  logic                    standby,
    input  logic [7:0]              avs_address,
    input  logic                    avs_read,
    input  logic                    avs_write,
    input  logic [31:0]             avs_writedata,
    input  logic [3:0]              avs_byteenable,
    output logic [31:0]             avs_readdata,
    output logic                    avs_waitrequest,
    input  logic [NCH-1:0]          request_in_n,
    input  logic [NCH-1:0]          periph_req,
    input  logic                    nmi_in,
    input  logic                    addr_err,
    input  logic [NCH-1:0]          xfer_done,
    output logic [NCH-1:0]          xfer_req,
    output logic [NCH-1:0][1:0]     xfer_size,
    output logic [NCH-1:0]          xfer_burst,
    output logic [NCH-1:0]          xfer_irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    dcec_bus_t              bus_st;
    logic                   rd_fire;
    logic                   wr_fire;
    logic [NCH-1:0]         sel_ctl;
    logic [NCH-1:0]         sel_cnt;
    logic                   sel_op;
    logic [31:0]            rd_val;

    logic                   master_enable;
    logic                   nmi_seen_flag;
    logic                   ae;

    logic [NCH-1:0]         de;
    logic [NCH-1:0]         ie;
    logic [NCH-1:0]         tm;
    logic [NCH-1:0]         ds;
    logic [NCH-1:0]         te;
    logic [NCH-1:0][1:0]    ts;
    logic [NCH-1:0][3:0]    rs;
    logic [NCH-1:0][CW-1:0] cnt;
    logic [NCH-1:0]         run;
    logic [NCH-1:0]         chan_en;
    logic [NCH-1:0]         want;
    logic [NCH-1:0]         grant;
    logic [NCH-1:0]         done_ok;
    logic [NCH-1:0]         last;
    logic [NCH-1:0]         pending;
    logic                   found;

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode and read mux

    always_comb
    begin
        sel_ctl = '0;
        sel_cnt = '0;
        sel_op  = ({avs_address[7:2], 2'b00} == DCEC_OFS_OPER);
        for (int i = 0; i < NCH; i++)
        begin
            if ({avs_address[7:2], 2'b00} == 8'(i * DCEC_CH_STRIDE + DCEC_OFS_CTRL))
                sel_ctl[i] = 1'b1;
            if ({avs_address[7:2], 2'b00} == 8'(i * DCEC_CH_STRIDE + DCEC_OFS_COUNT))
                sel_cnt[i] = 1'b1;
        end
    end

    always_comb
    begin
        rd_val = 32'h0000_0000;
        if (sel_op)
            rd_val = {29'h0000_0000, ae, nmi_seen_flag, master_enable};
        for (int i = 0; i < NCH; i++)
        begin
            if (sel_ctl[i])
                rd_val = {20'h0_0000, rs[i], 1'b0, ds[i], tm[i], ts[i], ie[i], te[i], de[i]};
            if (sel_cnt[i])
                rd_val = 32'(cnt[i]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Avalon slave, one wait cycle per access

    assign rd_fire = (bus_st == DCEC_BUS_ANSWER) && avs_read;
    assign wr_fire = (bus_st == DCEC_BUS_ANSWER) && avs_write;

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            bus_st          <= DCEC_BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end
        else if (ce)
        begin
            unique case (bus_st)
                DCEC_BUS_IDLE:
                begin
                    if (avs_read || avs_write)
                    begin
                        bus_st          <= DCEC_BUS_ANSWER;
                        avs_waitrequest <= 1'b0;
                        avs_readdata    <= avs_read ? rd_val : 32'h0000_0000;
                    end
                end
                DCEC_BUS_ANSWER:
                begin
                    bus_st          <= DCEC_BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Operation register

    always_ff @(posedge clk)
    begin
        if (!rstn)
            master_enable <= DCEC_OPER_RST[DCEC_B_DME];
        else if (ce)
        begin
            if (standby)
                master_enable <= 1'b0;
            else if (wr_fire && sel_op && avs_byteenable[0])
                master_enable <= avs_writedata[DCEC_B_DME];
        end
    end

    // NMI flag set on every NMI
    dcec_flag u_nmi_seen_flag
    (
        .clk       (clk),
        .rstn      (rstn),
        .ce        (ce),
        .clear_all (standby),
        .set       (nmi_in),
        .rd_one    (rd_fire && sel_op && avs_readdata[DCEC_B_NMI_SEEN_FLAG]),
        .wr_any    (wr_fire && sel_op && avs_byteenable[0]),
        .wr_val    (avs_writedata[DCEC_B_NMI_SEEN_FLAG]),
        .flag      (nmi_seen_flag)
    );

    // Address error during transfer sets flag
    dcec_flag u_ae
    (
        .clk       (clk),
        .rstn      (rstn),
        .ce        (ce),
        .clear_all (standby),
        .set       (addr_err && (|run)),
        .rd_one    (rd_fire && sel_op && avs_readdata[DCEC_B_AE]),
        .wr_any    (wr_fire && sel_op && avs_byteenable[0]),
        .wr_val    (avs_writedata[DCEC_B_AE]),
        .flag      (ae)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Fixed priority, lowest channel wins the bus

    always_comb
    begin
        grant = '0;
        found = 1'b0;
        for (int i = 0; i < NCH; i++)
        begin
            if (want[i] && !found && !(|run))
            begin
                grant[i] = 1'b1;
                found    = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Channels

    for (genvar g = 0; g < NCH; g++)
    begin : g_ch
        dcec_req_if rq ();

        assign rq.pin_n    = request_in_n[g];
        assign rq.periph   = periph_req[g];
        assign rq.ext_mode = dcec_is_ext(rs[g]);
        assign rq.edge_sel = ds[g];
        assign rq.armed    = chan_en[g];
        assign rq.consume  = grant[g];
        assign pending[g]  = rq.pending;

        dcec_req_sense u_sense
        (
            .clk  (clk),
            .rstn (rstn),
            .ce   (ce),
            .rq   (rq.sense)
        );

        // All flags, the channel enable and the master enable gate the channel
        assign chan_en[g] = de[g] && master_enable && !te[g] && !nmi_seen_flag && !ae
                            && (ts[g] != DCEC_SZ_BAD);
        assign want[g]    = chan_en[g] && (dcec_is_auto(rs[g]) || pending[g]);
        assign done_ok[g] = xfer_done[g] && run[g] && chan_en[g];
        assign last[g]    = (cnt[g] == CW'(1));

        always_ff @(posedge clk)
        begin
            if (!rstn)
            begin
                de[g] <= DCEC_CTRL_RST[DCEC_B_DE];
                ie[g] <= DCEC_CTRL_RST[DCEC_B_IE];
                tm[g] <= DCEC_CTRL_RST[DCEC_B_TM];
                ds[g] <= DCEC_CTRL_RST[DCEC_B_DS];
                ts[g] <= DCEC_CTRL_RST[DCEC_B_TS +: 2];
                rs[g] <= DCEC_CTRL_RST[DCEC_B_RS +: 4];
            end
            else if (ce && wr_fire && sel_ctl[g])
            begin
                if (avs_byteenable[0])
                begin
                    de[g] <= avs_writedata[DCEC_B_DE];
                    ie[g] <= avs_writedata[DCEC_B_IE];
                    tm[g] <= avs_writedata[DCEC_B_TM];
                    ds[g] <= avs_writedata[DCEC_B_DS];
                    ts[g] <= avs_writedata[DCEC_B_TS +: 2];
                end
                if (avs_byteenable[1])
                    rs[g] <= avs_writedata[DCEC_B_RS +: 4];
            end
        end

        always_ff @(posedge clk)
        begin
            if (!rstn)
                cnt[g] <= '0;
            else if (ce)
            begin
                if (wr_fire && sel_cnt[g])
                begin
                    for (int b = 0; b < 4; b++)
                        if (avs_byteenable[b])
                            for (int k = 0; k < 8; k++)
                                if (b * 8 + k < CW)
                                    cnt[g][b * 8 + k] <= avs_writedata[b * 8 + k];
                end
                else if (done_ok[g])
                    cnt[g] <= cnt[g] - CW'(1);
            end
        end

        // Flag set on last unit only
        dcec_flag u_te
        (
            .clk       (clk),
            .rstn      (rstn),
            .ce        (ce),
            .clear_all (standby),
            .set       (done_ok[g] && last[g]),
            .rd_one    (rd_fire && sel_ctl[g] && avs_readdata[DCEC_B_TE]),
            .wr_any    (wr_fire && sel_ctl[g] && avs_byteenable[0]),
            .wr_val    (avs_writedata[DCEC_B_TE]),
            .flag      (te[g])
        );

        // Loss of enable suspends the channel
        // Burst keeps the bus between units
        always_ff @(posedge clk)
        begin
            if (!rstn)
                run[g] <= 1'b0;
            else if (ce)
            begin
                if (!chan_en[g])
                    run[g] <= 1'b0;
                else if (done_ok[g])
                    run[g] <= tm[g] && !last[g];
                else if (grant[g])
                    run[g] <= 1'b1;
            end
        end

        // Interrupt request from flag and enable
        always_ff @(posedge clk)
        begin
            if (!rstn)
                xfer_irq[g] <= 1'b0;
            else if (ce)
                xfer_irq[g] <= te[g] && ie[g];
        end

        // Size and mode straight from control
        assign xfer_req[g]   = run[g];
        assign xfer_size[g]  = ts[g];
        assign xfer_burst[g] = tm[g];

        ////////////////////////////////////////////////////////////////////////////
        // Checks

        AST_TE_SET: assert property (@(posedge clk) disable iff (!rstn)
            (ce && done_ok[g] && last[g] && !standby) |=> te[g])
            else $error("transfer end flag missed last unit");

        AST_TE_EARLY: assert property (@(posedge clk) disable iff (!rstn)
            (!te[g] && !chan_en[g]) |=> !te[g])
            else $error("transfer end flag set without completion");

        AST_TE_BLOCK: assert property (@(posedge clk) disable iff (!rstn)
            (ce && te[g]) |=> !run[g])
            else $error("channel runs while transfer end flag set");

        AST_DE_STOP: assert property (@(posedge clk) disable iff (!rstn)
            (ce && !de[g]) |=> !run[g])
            else $error("channel runs with enable clear");

        AST_COUNT_DEC: assert property (@(posedge clk) disable iff (!rstn)
            (ce && done_ok[g] && !(wr_fire && sel_cnt[g]))
            |=> cnt[g] == $past(cnt[g]) - CW'(1))
            else $error("count did not step down");

        AST_IRQ: assert property (@(posedge clk) disable iff (!rstn)
            (ce && te[g] && ie[g]) ##1 ce |=> xfer_irq[g] || !te[g] || !ie[g])
            else $error("completion interrupt missing");

        AST_TE_WR1: assert property (@(posedge clk) disable iff (!rstn)
            (ce && wr_fire && sel_ctl[g] && avs_writedata[DCEC_B_TE] && te[g] && !standby)
            |=> te[g])
            else $error("write of one changed transfer end flag");

        AST_STEAL: assert property (@(posedge clk) disable iff (!rstn)
            (ce && done_ok[g] && !tm[g]) |=> !run[g])
            else $error("cycle steal held the bus");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Global checks

    AST_NMI_SET: assert property (@(posedge clk) disable iff (!rstn)
        (ce && nmi_in && !standby) |=> nmi_seen_flag)
        else $error("nmi flag not set");

    AST_MASTER: assert property (@(posedge clk) disable iff (!rstn)
        (ce && (!master_enable || nmi_seen_flag || ae)) |=> (run == '0))
        else $error("channel runs while controller blocked");

    AST_START: assert property (@(posedge clk) disable iff (!rstn)
        (ce && (|want) && !(|run)) |=> (|run))
        else $error("enabled request did not start");

    AST_OPER_ZERO: assert property (@(posedge clk) disable iff (!rstn)
        (bus_st == DCEC_BUS_IDLE && avs_read && sel_op && ce)
        |=> avs_readdata[31:3] == 29'h0000_0000)
        else $error("operation register upper bits not zero");

    AST_STANDBY: assert property (@(posedge clk) disable iff (!rstn)
        (ce && standby) |=> (!master_enable && !nmi_seen_flag && !ae))
        else $error("standby left operation register set");

endmodule : dcec_top

/* File: include/dcec_pkg.sv */
package dcec_pkg;

    // Channel count and transfer count width
    localparam int DCEC_NUM_CH  = 2;
    localparam int DCEC_COUNT_W = 24;

    // Register byte offsets
    localparam logic [7:0] DCEC_CH_STRIDE = 8'h10;
    localparam logic [7:0] DCEC_OFS_CTRL  = 8'h00;
    localparam logic [7:0] DCEC_OFS_COUNT = 8'h04;
    localparam logic [7:0] DCEC_OFS_OPER  = 8'h40;

    // Channel control field positions
    localparam int DCEC_B_DE = 0;
    localparam int DCEC_B_TE = 1;
    localparam int DCEC_B_IE = 2;
    localparam int DCEC_B_TS = 3;
    localparam int DCEC_B_TM = 5;
    localparam int DCEC_B_DS = 6;
    localparam int DCEC_B_RS = 8;

    // Operation register field positions
    localparam int DCEC_B_DME  = 0;
    localparam int DCEC_B_NMI_SEEN_FLAG = 1;
    localparam int DCEC_B_AE   = 2;

    // Values after reset
    localparam logic [31:0] DCEC_CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] DCEC_OPER_RST = 16'h0000;

    // Request source codes
    localparam logic [3:0] DCEC_RS_EXT_DUAL = 4'h0;
    localparam logic [3:0] DCEC_RS_EXT_SA2D = 4'h2;
    localparam logic [3:0] DCEC_RS_EXT_SD2A = 4'h3;
    localparam logic [3:0] DCEC_RS_AUTO     = 4'h4;

    typedef enum logic [1:0] {
        DCEC_SZ_BYTE = 2'b00,
        DCEC_SZ_WORD = 2'b01,
        DCEC_SZ_LONG = 2'b10,
        DCEC_SZ_BAD  = 2'b11
    } dcec_size_t;

    typedef enum logic {
        DCEC_BUS_IDLE   = 1'b0,
        DCEC_BUS_ANSWER = 1'b1
    } dcec_bus_t;

    function automatic logic dcec_is_auto(input logic [3:0] rs);
        return rs == DCEC_RS_AUTO;
    endfunction : dcec_is_auto

    function automatic logic dcec_is_ext(input logic [3:0] rs);
        return (rs == DCEC_RS_EXT_DUAL) || (rs == DCEC_RS_EXT_SA2D) || (rs == DCEC_RS_EXT_SD2A);
    endfunction : dcec_is_ext

endpackage : dcec_pkg

/* File: include/dcec_req_if.sv */
`timescale 1ns/1ps
interface dcec_req_if;
    logic pin_n;
    logic periph;
    logic ext_mode;
    logic edge_sel;
    logic armed;
    logic consume;
    logic pending;

    modport sense
    (
        input  pin_n, periph, ext_mode, edge_sel, armed, consume,
        output pending
    );
    modport ctrl
    (
        output pin_n, periph, ext_mode, edge_sel, armed, consume,
        input  pending
    );
endinterface : dcec_req_if

/* File: hdl/dcec_req_sense.sv */
`timescale 1ns/1ps
module dcec_req_sense
(
    input  logic   clk,
    input  logic   rstn,
    input  logic   ce,
    dcec_req_if.sense rq
);
    logic prev_n;
    logic prev_p;
    logic pend;
    logic edge_hit;
    logic level_mode;

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            prev_n <= 1'b1;
            prev_p <= 1'b0;
        end
        else if (ce)
        begin
            prev_n <= rq.pin_n;
            prev_p <= rq.periph;
        end
    end

    assign edge_hit   = rq.ext_mode ? (prev_n & ~rq.pin_n) : (~prev_p & rq.periph);
    // Sense bit picks level or edge for external requests; peripheral requests are always edge
    assign level_mode = rq.ext_mode & ~rq.edge_sel;

    always_ff @(posedge clk)
    begin
        if (!rstn)
            pend <= 1'b0;
        else if (ce)
        begin
            if (!rq.armed)
                pend <= 1'b0;
            else if (edge_hit)
                pend <= 1'b1;
            else if (rq.consume)
                pend <= 1'b0;
        end
    end

    assign rq.pending = level_mode ? ~rq.pin_n : pend;
endmodule : dcec_req_sense

/* File: hdl/dcec_flag.sv */
`timescale 1ns/1ps
module dcec_flag
(
    input  logic clk,
    input  logic rstn,
    input  logic ce,
    input  logic clear_all,
    input  logic set,
    input  logic rd_one,
    input  logic wr_any,
    input  logic wr_val,
    output logic flag
);
    logic armed;

    // Zero write clears only after a one read
    always_ff @(posedge clk)
    begin
        if (!rstn)
            armed <= 1'b0;
        else if (ce)
        begin
            if (clear_all || wr_any)
                armed <= 1'b0;
            else if (rd_one)
                armed <= 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            flag <= 1'b0;
        else if (ce)
        begin
            if (clear_all)
                flag <= 1'b0;
            else if (set)
                flag <= 1'b1;
            else if (wr_any && !wr_val && armed)
                flag <= 1'b0;
        end
    end
endmodule : dcec_flag

/* File: tb/dcec_partner.sv */
`timescale 1ns/1ps
module dcec_partner
    import dcec_pkg::*;
#(
    parameter int NCH = DCEC_NUM_CH
)
(
    input  logic                 clk,
    input  logic                 rstn,
    input  logic [NCH-1:0]       xfer_req,
    input  logic [7:0]           lat,
    output logic [NCH-1:0]       xfer_done,
    output logic [NCH-1:0][15:0] done_cnt
);
    logic [NCH-1:0][7:0] wait_cnt;

    ////////////////////////////////////////////////////////////////////////////////
    // One pulse per unit
    always_ff @(posedge clk)
    begin
        for (int c = 0; c < NCH; c++)
        begin
            xfer_done[c] <= 1'b0;
            if (!rstn)
            begin
                done_cnt[c] <= 16'h0000;
            end
            if (!rstn || !xfer_req[c] || xfer_done[c])
            begin
                wait_cnt[c] <= 8'h00;
            end
            else if (wait_cnt[c] == lat)
            begin
                xfer_done[c] <= 1'b1;
                wait_cnt[c]  <= 8'h00;
                done_cnt[c]  <= done_cnt[c] + 16'h0001;
            end
            else
            begin
                wait_cnt[c] <= wait_cnt[c] + 8'h01;
            end
        end
    end
endmodule : dcec_partner

/* File: tb/dcec_top_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %s exp=%h got=%h", nm, (e), (g)); end end
module dcec_top_tb
    import dcec_pkg::*;
;
    logic             clk = 1'b0;
    logic             rstn = 1'b0;
    logic             standby = 1'b0;
    logic [7:0]       avs_address = 8'h00;
    logic             avs_read = 1'b0;
    logic             avs_write = 1'b0;
    logic [31:0]      avs_writedata = 32'h0000_0000;
    logic [31:0]      avs_readdata;
    logic             avs_waitrequest;
    logic [1:0]       request_in_n = 2'b11;
    logic [1:0]       periph_req = 2'b00;
    logic             nmi_in = 1'b0;
    logic             addr_err = 1'b0;
    logic [1:0]       xfer_done;
    logic [1:0]       xfer_req;
    logic [1:0]       xfer_burst;
    logic [1:0]       xfer_irq;
    logic [1:0][1:0]  xfer_size;
    logic [1:0][15:0] done_cnt;
    logic [7:0]       lat = 8'h02;
    logic [31:0]      q;
    logic [31:0]      d;
    logic [7:0]       a;
    logic [31:0]      auto_on;
    logic [3:0]       src_tab [5] = '{4'h0, 4'h3, 4'h6, 4'h4, 4'h2};
    logic             sense_tab [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    int               err_count = 0;
    int               n_tests = 0;
    int               seed = 90460;

    always #12.5 clk = ~clk;

    dcec_top dcec_top_inst (.clk(clk), .rstn(rstn), .ce(1'b1), .standby(standby),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .request_in_n(request_in_n),
        .periph_req(periph_req), .nmi_in(nmi_in), .addr_err(addr_err),
        .xfer_done(xfer_done), .xfer_req(xfer_req), .xfer_size(xfer_size),
        .xfer_burst(xfer_burst), .xfer_irq(xfer_irq));

    dcec_partner dcec_partner_inst (.clk(clk), .rstn(rstn), .xfer_req(xfer_req),
        .lat(lat), .xfer_done(xfer_done), .done_cnt(done_cnt));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] ctrl_exp(input logic [31:0] v);
        return v & 32'h0000_0F7D;
    endfunction : ctrl_exp

    function automatic logic [31:0] oper_exp(input int k);
        return (k == 0) ? 32'h0000_0005 : (k == 1) ? 32'h0000_0003 :
               (k == 2) ? 32'h0000_0000 : 32'h0000_0001;
    endfunction : oper_exp

    task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        int t;
        t = 0;
        @(posedge clk);
        avs_address   <= ad;
        avs_writedata <= wd;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do
        begin
            @(posedge clk);
            t++;
        end
        while (avs_waitrequest !== 1'b0 && t < 50);
        if (t >= 50)
        begin
            err_count++;
            $display("[ERR] bus waitrequest exp=0 got=1");
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    task automatic quiet(input int n);
        repeat (n)
        begin
            @(posedge clk);
            `CHK("xfer_req idle", 2'b00, xfer_req)
        end
    endtask : quiet

    task automatic wait_end();
        int t;
        t = 0;
        do
        begin
            bus(1'b0, DCEC_OFS_CTRL, 32'h0);
            t++;
        end
        while (q[DCEC_B_TE] !== 1'b1 && t < 100);
        `CHK("end flag", 1'b1, q[DCEC_B_TE])
    endtask : wait_end

    task automatic wait_req();
        int t;
        t = 0;
        while (xfer_req[0] !== 1'b1 && t < 100)
        begin
            @(posedge clk);
            t++;
        end
        `CHK("xfer_req up", 1'b1, xfer_req[0])
    endtask : wait_req

    task automatic run_auto(input logic [31:0] mode, input int n);
        logic [15:0] base;
        base = done_cnt[0];
        bus(1'b1, DCEC_OFS_COUNT, 32'(n));
        bus(1'b1, DCEC_OFS_CTRL, auto_on | mode);
        wait_end();
        repeat (2) @(posedge clk);
        `CHK("units", 16'(n), 16'(done_cnt[0] - base))
        `CHK("irq", mode[DCEC_B_IE], xfer_irq[0])
    endtask : run_auto

    task automatic give_verdict();
        $display("checks=%0d errors=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #1000000;
        err_count++;
        $display("[ERR] watchdog expired");
        give_verdict();
    end

    initial
    begin
        auto_on = (32'(DCEC_RS_AUTO) << DCEC_B_RS) | 32'h0000_0001;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        bus(1'b0, DCEC_OFS_CTRL, 32'h0);
        `CHK("ctrl0 reset", DCEC_CTRL_RST, q)
        bus(1'b0, DCEC_CH_STRIDE, 32'h0);
        `CHK("ctrl1 reset", DCEC_CTRL_RST, q)
        bus(1'b0, DCEC_OFS_OPER, 32'h0);
        `CHK("oper reset", 32'(DCEC_OPER_RST), q)
        bus(1'b0, 8'h80, 32'h0);
        `CHK("unmapped", 32'h0000_0000, q)
        bus(1'b1, DCEC_OFS_OPER, 32'hFFFF_FFFF);
        bus(1'b0, DCEC_OFS_OPER, 32'h0);
        `CHK("oper ones", 32'h0000_0001, q)
        bus(1'b1, DCEC_OFS_OPER, 32'h0);
        for (int i = 0; i < 12; i++)
        begin
            d = $random(seed);
            d[4:3] = 2'(i % 3);
            d[0] = 1'b0;
            a = (i % 2) ? DCEC_CH_STRIDE : DCEC_OFS_CTRL;
            bus(1'b1, a, d);
            bus(1'b0, a, 32'h0);
            `CHK("ctrl", ctrl_exp(d), q)
            `CHK("size", d[4:3], xfer_size[i % 2])
            `CHK("burst", d[5], xfer_burst[i % 2])
        end
        bus(1'b1, DCEC_CH_STRIDE, 32'h0);
        bus(1'b1, DCEC_OFS_COUNT, 32'h1);
        bus(1'b1, DCEC_OFS_CTRL, auto_on);
        quiet(10);
        bus(1'b1, DCEC_OFS_CTRL, 32'h0);
        bus(1'b1, DCEC_OFS_OPER, 32'h1);
        run_auto(32'h0000_0004, 3);
        quiet(20);
        bus(1'b1, DCEC_OFS_CTRL, 32'h0000_0007);
        bus(1'b1, DCEC_OFS_CTRL, 32'h0000_0004);
        bus(1'b0, DCEC_OFS_CTRL, 32'h0);
        `CHK("flag kept", 1'b1, q[DCEC_B_TE])
        bus(1'b1, DCEC_OFS_CTRL, 32'h0);
        bus(1'b0, DCEC_OFS_CTRL, 32'h0);
        `CHK("flag cleared", 32'h0000_0000, q)
        repeat (2) @(posedge clk);
        `CHK("irq off", 1'b0, xfer_irq[0])
        run_auto(32'h0000_0020, 2);
        bus(1'b1, DCEC_OFS_CTRL, 32'h0);
        lat <= 8'd40;
        for (int k = 0; k < 4; k++)
        begin
            bus(1'b1, DCEC_OFS_OPER, 32'h1);
            bus(1'b1, DCEC_OFS_COUNT, 32'h5);
            bus(1'b1, DCEC_OFS_CTRL, auto_on);
            wait_req();
            if (k == 0)
                addr_err <= 1'b1;
            else if (k == 1)
                nmi_in <= 1'b1;
            else if (k == 2)
                bus(1'b1, DCEC_OFS_OPER, 32'h0);
            else
                bus(1'b1, DCEC_OFS_CTRL, auto_on & ~32'h1);
            @(posedge clk);
            addr_err <= 1'b0;
            nmi_in   <= 1'b0;
            repeat (2) @(posedge clk);
            quiet(8);
            bus(1'b0, DCEC_OFS_OPER, 32'h0);
            `CHK("oper after stop", oper_exp(k), q)
            bus(1'b0, DCEC_OFS_CTRL, 32'h0);
            `CHK("no end flag", 1'b0, q[DCEC_B_TE])
            bus(1'b1, DCEC_OFS_OPER, 32'h0);
            bus(1'b0, DCEC_OFS_OPER, 32'h0);
            `CHK("oper cleared", 32'h0000_0000, q)
        end
        lat <= 8'd2;
        bus(1'b1, DCEC_OFS_OPER, 32'h1);
        for (int j = 0; j < 5; j++)
        begin
            request_in_n[0] <= 1'b0;
            periph_req[0]   <= 1'b1;
            bus(1'b1, DCEC_OFS_COUNT, 32'h1);
            bus(1'b1, DCEC_OFS_CTRL, (32'(src_tab[j]) << DCEC_B_RS) |
                (32'(sense_tab[j]) << DCEC_B_DS) | 32'h1);
            if (!(src_tab[j] == DCEC_RS_AUTO || (src_tab[j] == 4'h0 && !sense_tab[j])))
            begin
                quiet(10);
                request_in_n[0] <= 1'b1;
                periph_req[0]   <= 1'b0;
                repeat (2) @(posedge clk);
                request_in_n[0] <= 1'b0;
                periph_req[0]   <= 1'b1;
            end
            wait_end();
            bus(1'b1, DCEC_OFS_CTRL, 32'h0);
        end
        bus(1'b1, DCEC_OFS_COUNT, 32'h1);
        bus(1'b1, DCEC_OFS_CTRL, auto_on);
        wait_end();
        standby <= 1'b1;
        @(posedge clk);
        standby <= 1'b0;
        bus(1'b0, DCEC_OFS_OPER, 32'h0);
        `CHK("oper standby", 32'h0000_0000, q)
        bus(1'b0, DCEC_OFS_CTRL, 32'h0);
        `CHK("flag standby", 1'b0, q[DCEC_B_TE])
        give_verdict();
    end
endmodule : dcec_top_tb
